/* lux_cfg.svh */
// constants for the lux result and identity register block
//
// Contract
// - skip clear: cycle is integration plus 60/factor ms
// - skip set: next integration starts at once
// - result is one 16-bit word, two bytes
// - low byte 0x04, high 0x05, read-only
// - result reported directly in lux
// - identity register 0x0A, code bits 7:4
// - part code fixed, one per variant
// - select 00/01/10 gives 400/200/100 ms, factor 1/2/4
// - results pass a double buffer, never mixed
// - read pointer auto-advances, skipping unimplemented registers
`ifndef LUX_CFG_SVH
`define LUX_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define LUX_OFS_CONTROL     4'h0
`define LUX_OFS_CONFIG      4'h1
`define LUX_OFS_RESULT_LOW  4'h4
`define LUX_OFS_RESULT_HIGH 4'h5
`define LUX_OFS_KIND        4'hA

// ****************************************
// field positions and reset values
// ****************************************
`define LUX_CMD_SELECT_BIT  7
`define LUX_CFG_SKIP_BIT    3
`define LUX_MODE_OFF        2'h0
`define LUX_MODE_SINGLE     2'h2
`define LUX_MODE_NORMAL     2'h3
`define LUX_TSEL_RESERVED   2'h3
`define LUX_TSEL_SHORTEST   2'h2
`define LUX_RESET_BYTE      8'h00
`define LUX_RESET_WORD      16'h0000
`define LUX_PART_CODE       4'h3  // arbitrary code
`define LUX_SLAVE_ADDR      7'h4C // arbitrary bus address

// ****************************************
// timing
// ****************************************
`define LUX_CLK_PERIOD_NS   25
`define LUX_MS_NS           1000000
`define LUX_MS_CYCLES       (`LUX_MS_NS / `LUX_CLK_PERIOD_NS)
`define LUX_TINT_MAX_MS     9'd400
`define LUX_PSAVE_MS        9'd60

`endif

/* lux_pkg.sv */
// types for the lux result and identity register block
package lux_pkg;

    typedef enum {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_WRITE,
        BUS_WRITE_ACK,
        BUS_READ,
        BUS_READ_ACK
    } bus_state_t;

    typedef enum {
        MEAS_OFF,
        MEAS_INTEG,
        MEAS_SAVE
    } meas_state_t;

    typedef struct packed {
        logic [1:0]  scl_sync;
        logic [1:0]  sda_sync;
        logic        scl_q;
        logic        sda_q;
        bus_state_t  bus;
        logic [2:0]  bit_cnt;
        logic [7:0]  shift;
        logic        ack_flag;
        logic        first_byte;
        logic [3:0]  pointer;
        logic        sda_oe;
        logic        sda_out;
        logic [1:0]  mode;
        logic        power_save_skip;
        logic [1:0]  integration_time_select;
        logic [15:0] result;
        logic [15:0] pending;
        logic        pending_valid;
        meas_state_t meas;
        logic [31:0] ms_div;
        logic [8:0]  ms_cnt;
        logic        integrating;
    } lux_state_t;

endpackage : lux_pkg

/* lux_result_and_identity_regs.sv */
// i2c register slave with measurement cycle timing and result buffer
`timescale 1ns/1ps
`default_nettype none
`include "lux_cfg.svh"

module lux_result_and_identity_regs #(
    parameter int unsigned MS_CYCLES = `LUX_MS_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // i2c pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // analog integrator
    input  wire logic [15:0] adc_value,
    output logic             integrating
);
    import lux_pkg::*;

    lux_state_t st_reg;
    lux_state_t st_next;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [1:0] eff_tsel(input logic [1:0] t);
        eff_tsel = (t == `LUX_TSEL_RESERVED) ? `LUX_TSEL_SHORTEST : t;
    endfunction : eff_tsel

    function automatic logic [8:0] integ_ms(input logic [1:0] t);
        integ_ms = `LUX_TINT_MAX_MS >> eff_tsel(t);
    endfunction : integ_ms

    function automatic logic [8:0] save_ms(input logic [1:0] t);
        save_ms = `LUX_PSAVE_MS >> eff_tsel(t);
    endfunction : save_ms

    function automatic logic [3:0] next_ptr(input logic [3:0] p);
        case (p)
            `LUX_OFS_CONTROL:     next_ptr = `LUX_OFS_CONFIG;
            `LUX_OFS_CONFIG:      next_ptr = `LUX_OFS_RESULT_LOW;
            `LUX_OFS_RESULT_LOW:  next_ptr = `LUX_OFS_RESULT_HIGH;
            `LUX_OFS_RESULT_HIGH: next_ptr = `LUX_OFS_KIND;
            default:              next_ptr = `LUX_OFS_CONTROL;
        endcase
    endfunction : next_ptr

    function automatic logic [7:0] reg_read(input lux_state_t s);
        case (s.pointer)
            `LUX_OFS_CONTROL:     reg_read = {6'h00, s.mode};
            `LUX_OFS_CONFIG:      reg_read = {4'h0, s.power_save_skip, 1'b0,
                                              s.integration_time_select};
            `LUX_OFS_RESULT_LOW:  reg_read = s.result[7:0];
            `LUX_OFS_RESULT_HIGH: reg_read = s.result[15:8];
            `LUX_OFS_KIND:        reg_read = {`LUX_PART_CODE, 4'h0};
            default:              reg_read = `LUX_RESET_BYTE;
        endcase
    endfunction : reg_read

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic scl_s;
        logic sda_s;
        logic rise;
        logic fall;
        logic start_c;
        logic stop_c;
        logic [7:0] rx;
        logic [7:0] tx;
        logic conv_done;
        scl_s = st_reg.scl_sync[1];
        sda_s = st_reg.sda_sync[1];
        rise = scl_s & ~st_reg.scl_q;
        fall = ~scl_s & st_reg.scl_q;
        start_c = scl_s & st_reg.scl_q & st_reg.sda_q & ~sda_s;
        stop_c = scl_s & st_reg.scl_q & ~st_reg.sda_q & sda_s;
        rx = {st_reg.shift[6:0], sda_s};
        tx = reg_read(st_reg);
        conv_done = 1'b0;

        st_next = st_reg;
        st_next.scl_sync = {st_reg.scl_sync[0], scl_in};
        st_next.sda_sync = {st_reg.sda_sync[0], sda_in};
        st_next.scl_q = scl_s;
        st_next.sda_q = sda_s;
        st_next.sda_out = 1'b0;

        // bus side
        if (start_c) begin
            st_next.bus = BUS_ADDR;
            st_next.bit_cnt = 3'h0;
            st_next.sda_oe = 1'b0;
        end else if (stop_c) begin
            st_next.bus = BUS_IDLE;
            st_next.sda_oe = 1'b0;
        end else begin
            case (st_reg.bus)
                BUS_ADDR: begin
                    if (rise) begin
                        st_next.shift = rx;
                        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                        if (st_reg.bit_cnt == 3'h7) begin
                            st_next.bus = BUS_ADDR_ACK;
                            st_next.ack_flag = 1'b0;
                        end
                    end
                end
                BUS_ADDR_ACK: begin
                    if (fall) begin
                        if (!st_reg.ack_flag) begin
                            if (st_reg.shift[7:1] == `LUX_SLAVE_ADDR) begin
                                st_next.sda_oe = 1'b1;
                                st_next.ack_flag = 1'b1;
                            end else begin
                                st_next.bus = BUS_IDLE;
                            end
                        end else begin
                            st_next.ack_flag = 1'b0;
                            st_next.bit_cnt = 3'h0;
                            if (st_reg.shift[0]) begin
                                st_next.bus = BUS_READ;
                                st_next.shift = tx;
                                st_next.sda_oe = ~tx[7];
                                st_next.pointer = next_ptr(st_reg.pointer);
                            end else begin
                                st_next.bus = BUS_WRITE;
                                st_next.sda_oe = 1'b0;
                                st_next.first_byte = 1'b1;
                            end
                        end
                    end
                end
                BUS_WRITE: begin
                    if (rise) begin
                        st_next.shift = rx;
                        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                        if (st_reg.bit_cnt == 3'h7) begin
                            st_next.bus = BUS_WRITE_ACK;
                            st_next.ack_flag = 1'b0;
                            if (st_reg.first_byte) begin
                                st_next.first_byte = 1'b0;
                                if (rx[`LUX_CMD_SELECT_BIT]) begin
                                    st_next.pointer = rx[3:0];
                                end
                            end else begin
                                // result and identity writes are dropped
                                if (st_reg.pointer == `LUX_OFS_CONTROL) begin
                                    st_next.mode = rx[1:0];
                                end else if (st_reg.pointer == `LUX_OFS_CONFIG) begin
                                    st_next.power_save_skip = rx[`LUX_CFG_SKIP_BIT];
                                    st_next.integration_time_select = rx[1:0];
                                end
                                st_next.pointer = next_ptr(st_reg.pointer);
                            end
                        end
                    end
                end
                BUS_WRITE_ACK: begin
                    if (fall) begin
                        st_next.sda_oe = ~st_reg.ack_flag;
                        st_next.ack_flag = ~st_reg.ack_flag;
                        if (st_reg.ack_flag) begin
                            st_next.bus = BUS_WRITE;
                            st_next.bit_cnt = 3'h0;
                        end
                    end
                end
                BUS_READ: begin
                    if (fall) begin
                        if (st_reg.bit_cnt == 3'h7) begin
                            st_next.sda_oe = 1'b0;
                            st_next.bus = BUS_READ_ACK;
                            st_next.ack_flag = 1'b0;
                        end else begin
                            st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                            st_next.shift = {st_reg.shift[6:0], 1'b0};
                            st_next.sda_oe = ~st_reg.shift[6];
                        end
                    end
                end
                BUS_READ_ACK: begin
                    if (rise) begin
                        if (sda_s) begin
                            st_next.bus = BUS_IDLE;
                        end else begin
                            st_next.ack_flag = 1'b1;
                        end
                    end else if (fall && st_reg.ack_flag) begin
                        st_next.bus = BUS_READ;
                        st_next.bit_cnt = 3'h0;
                        st_next.shift = tx;
                        st_next.sda_oe = ~tx[7];
                        st_next.pointer = next_ptr(st_reg.pointer);
                    end
                end
                default: begin
                    st_next.sda_oe = 1'b0;
                end
            endcase
        end

        // measurement cycle
        if (st_reg.ms_div == MS_CYCLES - 1) begin
            st_next.ms_div = 32'h0;
        end else begin
            st_next.ms_div = st_reg.ms_div + 32'h1;
        end
        case (st_reg.meas)
            MEAS_OFF: begin
                if (st_reg.mode == `LUX_MODE_SINGLE || st_reg.mode == `LUX_MODE_NORMAL) begin
                    st_next.meas = MEAS_INTEG;
                    st_next.ms_cnt = integ_ms(st_reg.integration_time_select);
                    st_next.ms_div = 32'h0;
                end
            end
            MEAS_INTEG: begin
                if (st_reg.mode == `LUX_MODE_OFF) begin
                    st_next.meas = MEAS_OFF;
                end else if (st_reg.ms_div == MS_CYCLES - 1) begin
                    st_next.ms_cnt = st_reg.ms_cnt - 9'h1;
                    if (st_reg.ms_cnt == 9'h1) begin
                        conv_done = 1'b1;
                        if (st_reg.mode == `LUX_MODE_SINGLE) begin
                            st_next.mode = `LUX_MODE_OFF;
                            st_next.meas = MEAS_OFF;
                        end else if (st_reg.power_save_skip) begin
                            st_next.ms_cnt = integ_ms(st_reg.integration_time_select);
                        end else begin
                            st_next.meas = MEAS_SAVE;
                            st_next.ms_cnt = save_ms(st_reg.integration_time_select);
                        end
                    end
                end
            end
            MEAS_SAVE: begin
                if (st_reg.mode == `LUX_MODE_OFF) begin
                    st_next.meas = MEAS_OFF;
                end else if (st_reg.ms_div == MS_CYCLES - 1) begin
                    st_next.ms_cnt = st_reg.ms_cnt - 9'h1;
                    if (st_reg.ms_cnt == 9'h1) begin
                        st_next.meas = MEAS_INTEG;
                        st_next.ms_cnt = integ_ms(st_reg.integration_time_select);
                    end
                end
            end
            default: begin
                st_next.meas = MEAS_OFF;
            end
        endcase
        st_next.integrating = (st_next.meas == MEAS_INTEG);

        // result double buffer, held back while a transaction is open
        if (conv_done) begin
            st_next.pending = adc_value;
            st_next.pending_valid = 1'b1;
        end
        if (st_reg.pending_valid && st_reg.bus == BUS_IDLE && !conv_done) begin
            st_next.result = st_reg.pending;
            st_next.pending_valid = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '{
                scl_sync: 2'h3, sda_sync: 2'h3, scl_q: 1'b1, sda_q: 1'b1,
                bus: BUS_IDLE, bit_cnt: 3'h0, shift: `LUX_RESET_BYTE,
                ack_flag: 1'b0, first_byte: 1'b0, pointer: `LUX_OFS_CONTROL,
                sda_oe: 1'b0, sda_out: 1'b0, mode: `LUX_MODE_OFF,
                power_save_skip: 1'b0, integration_time_select: 2'h0,
                result: `LUX_RESET_WORD, pending: `LUX_RESET_WORD,
                pending_valid: 1'b0, meas: MEAS_OFF, ms_div: 32'h0,
                ms_cnt: 9'h0, integrating: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign sda_out = st_reg.sda_out;
    assign sda_oe = st_reg.sda_oe;
    assign integrating = st_reg.integrating;

endmodule : lux_result_and_identity_regs
`default_nettype wire

/* lux_regs_checker.sv */
// port checker for the lux result and identity register block
`timescale 1ns/1ps
`default_nettype none
module lux_regs_checker #(
    parameter int unsigned MS_CYCLES = 10
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // i2c pins
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    // analog integrator
    input wire logic [15:0] adc_value,
    input wire logic        integrating
);
    int unsigned run_cnt;
    int unsigned gap_cnt;
    logic        quiet;
    logic        sda_prev;
    logic        int_prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_cnt  <= 0;
            gap_cnt  <= 0;
            quiet    <= 1'b0;
            sda_prev <= 1'b1;
            int_prev <= 1'b0;
        end else begin
            run_cnt  <= integrating ? run_cnt + 1 : 0;
            gap_cnt  <= integrating ? 0 : gap_cnt + 1;
            sda_prev <= sda_in;
            int_prev <= integrating;
            // gap judged only with no bus start since the end
            if (scl_in && sda_prev && !sda_in) begin
                quiet <= 1'b0;
            end else if (int_prev && !integrating) begin
                quiet <= 1'b1;
            end
        end
    end

    function automatic bit near(input int unsigned g, input int unsigned n);
        return (g + 2 >= n) && (g <= n + 2);
    endfunction : near

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence hold_three;
        ##1 $stable(sda_oe) [*3];
    endsequence
    sequence stays_on;
        integrating [*8];
    endsequence

    open_drain_a: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    oe_rise_low_a: assert property ($rose(sda_oe) |-> !$past(scl_in, 2))
        else $error("sda pulled while scl high");
    oe_fall_low_a: assert property ($fell(sda_oe) |-> !$past(scl_in, 2))
        else $error("sda released while scl high");
    oe_hold_high_a: assert property ($rose(scl_in) |-> hold_three)
        else $error("sda changed during scl high");
    reset_quiet_a: assert property ($fell(rst) |-> (!integrating && !sda_oe) [*3])
        else $error("activity right after reset");
    integ_min_a: assert property ($rose(integrating) |-> stays_on)
        else $error("integration pulse too short");
    integ_len_a: assert property ($fell(integrating) |->
        (run_cnt + 2) % (100 * MS_CYCLES) <= 4)
        else $error("integration length wrong");
    save_gap_a: assert property ($rose(integrating) && quiet &&
        gap_cnt <= 60 * MS_CYCLES + 2 |-> gap_cnt <= 1 || near(gap_cnt, 15 * MS_CYCLES)
        || near(gap_cnt, 30 * MS_CYCLES) || near(gap_cnt, 60 * MS_CYCLES))
        else $error("power save gap wrong");
endmodule : lux_regs_checker

bind lux_result_and_identity_regs lux_regs_checker #(.MS_CYCLES(MS_CYCLES)) lux_regs_checker_inst (
    .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .adc_value(adc_value), .integrating(integrating));
`default_nettype wire

/* i2c_host_model.sv */
// i2c host controller model reaching the sensor registers
`timescale 1ns/1ps
`default_nettype none
`include "lux_cfg.svh"
module i2c_host_model (
    // clock
    input  wire logic clk,
    // bus pins
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    logic [7:0] rd [0:7];
    int         nacks;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
        nacks   = 0;
    end

    // set pins, then hold for half of an scl low or high phase
    task automatic drive(input logic c, input logic d);
        scl     = c;
        sda_low = !d;
        repeat (2) @(negedge clk);
    endtask : drive

    task automatic frame_start();
        drive(scl, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        drive(1'b0, 1'b0);
    endtask : frame_start

    task automatic frame_stop();
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
    endtask : frame_stop

    task automatic one_bit(input logic b, output logic r);
        drive(1'b0, b);
        drive(1'b1, b);
        r = sda;
        drive(1'b1, b);
        drive(1'b0, b);
    endtask : one_bit

    // msb first; write bytes check the ack, read bytes give one except the last, which gets a nack
    task automatic xfer(input logic [7:0] d, input bit wr, input bit last, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            one_bit(d[i], q[i]);
        end
        one_bit(wr ? 1'b1 : last, a);
        if (wr && a !== 1'b0) begin
            nacks++;
        end
    endtask : xfer

    task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
        logic [7:0] q;
        frame_start();
        xfer({`LUX_SLAVE_ADDR, 1'b0}, 1, 0, q);
        xfer({1'b1, 3'h0, addr}, 1, 0, q);
        xfer(data, 1, 0, q);
        frame_stop();
    endtask : reg_write

    task automatic reg_read(input logic [3:0] addr, input int n);
        logic [7:0] q;
        frame_start();
        xfer({`LUX_SLAVE_ADDR, 1'b0}, 1, 0, q);
        xfer({1'b1, 3'h0, addr}, 1, 0, q);
        frame_start();
        xfer({`LUX_SLAVE_ADDR, 1'b1}, 1, 0, q);
        for (int i = 0; i < n; i++) begin
            xfer(8'hFF, 0, i == n - 1, rd[i]);
        end
        frame_stop();
    endtask : reg_read
endmodule : i2c_host_model
`default_nettype wire

/* lux_result_and_identity_regs_bench.sv */
// self-checking bench for the lux result and identity register block
`timescale 1ns/1ps
`default_nettype none
`include "lux_cfg.svh"
module lux_result_and_identity_regs_bench;
    localparam int unsigned MS = 10;
    logic        clk;
    logic        rst;
    logic        scl;
    logic        sda_low;
    logic        sda_out;
    logic        sda_oe;
    logic        integrating;
    logic [15:0] adc;
    int          fails;
    int          samples_checked;
    int          run;
    int          last_run;
    int          n;
    wire logic   sda = !(sda_low || (sda_oe && !sda_out));

    lux_result_and_identity_regs #(.MS_CYCLES(MS)) lux_result_and_identity_regs_inst (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .adc_value(adc), .integrating(integrating));
    i2c_host_model i2c_host_model_inst (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));

    always #12.5 clk = ~clk;

    // length of the last integration pulse
    always @(posedge clk) begin
        if (integrating === 1'b1) begin
            run <= run + 1;
        end else begin
            if (run != 0) last_run <= run;
            run <= 0;
        end
    end

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic do_reset();
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
    endtask : do_reset

    task automatic wait_int(input logic lvl, input int limit);
        n = 0;
        while (integrating !== lvl && n < limit) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_int

    initial begin
        clk = 1'b0;
        adc = 16'h0000;
        do_reset();
        i2c_host_model_inst.reg_write(`LUX_OFS_KIND, 8'hFF);
        i2c_host_model_inst.reg_write(`LUX_OFS_RESULT_LOW, 8'h55);
        i2c_host_model_inst.reg_read(`LUX_OFS_CONTROL, 6);
        check_val(16'(i2c_host_model_inst.rd[0]), 16'h0000);
        check_val(16'(i2c_host_model_inst.rd[1]), 16'h0000);
        check_val(16'(i2c_host_model_inst.rd[2]), 16'h0000);
        check_val(16'(i2c_host_model_inst.rd[3]), 16'h0000);
        check_val(16'(i2c_host_model_inst.rd[4] & 8'hF0), 16'({`LUX_PART_CODE, 4'h0}));
        check_val(16'(i2c_host_model_inst.rd[5]), 16'h0000);
        // codes 00, 01, 10 only; 11 is never programmed
        for (int t = 0; t < 3; t++) begin
            adc = 16'h639C + 16'(t);
            i2c_host_model_inst.reg_write(`LUX_OFS_CONFIG, 8'(t));
            i2c_host_model_inst.reg_write(`LUX_OFS_CONTROL, {6'h00, `LUX_MODE_SINGLE});
            wait_int(1'b1, 500);
            wait_int(1'b0, 5000);
            @(negedge clk);
            check_val(16'((last_run + MS / 2) / MS), 16'(400 >> t));
            i2c_host_model_inst.reg_write(`LUX_OFS_RESULT_HIGH, 8'hFF);
            i2c_host_model_inst.reg_read(`LUX_OFS_RESULT_LOW, 3);
            check_val({i2c_host_model_inst.rd[1], i2c_host_model_inst.rd[0]}, adc);
            check_val(16'(i2c_host_model_inst.rd[2] & 8'hF0), 16'({`LUX_PART_CODE, 4'h0}));
        end
        for (int s = 0; s < 2; s++) begin
            do_reset();
            adc = 16'h1234;
            i2c_host_model_inst.reg_write(`LUX_OFS_CONFIG, {4'h0, 1'(s), 1'b0, `LUX_TSEL_SHORTEST});
            i2c_host_model_inst.reg_write(`LUX_OFS_CONTROL, {6'h00, `LUX_MODE_NORMAL});
            wait_int(1'b1, 500);
            repeat (1075) @(negedge clk);
            check_val(16'(integrating), 16'(s));
            repeat (100) @(negedge clk);
            check_val(16'(integrating), 16'h0001);
            i2c_host_model_inst.reg_read(`LUX_OFS_RESULT_LOW, 2);
            check_val({i2c_host_model_inst.rd[1], i2c_host_model_inst.rd[0]}, adc);
            // next conversion lands between the low and high byte loads
            adc = 16'h5678;
            repeat (308 - 150 * s) @(negedge clk);
            i2c_host_model_inst.reg_read(`LUX_OFS_RESULT_LOW, 2);
            check_val({i2c_host_model_inst.rd[1], i2c_host_model_inst.rd[0]}, 16'h1234);
            i2c_host_model_inst.reg_read(`LUX_OFS_RESULT_LOW, 2);
            check_val({i2c_host_model_inst.rd[1], i2c_host_model_inst.rd[0]}, 16'h5678);
        end
        check_val(16'(i2c_host_model_inst.nacks), 16'h0000);
        close_out();
    end

    initial begin
        fails = 0;
        samples_checked = 0;
        repeat (40000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule : lux_result_and_identity_regs_bench
`default_nettype wire
